/* src/aec_defs.svh */
`ifndef AEC_DEFS_SVH
`define AEC_DEFS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define AEC_OFF_CTRL      5'h00
`define AEC_OFF_CLKSEL    5'h04
`define AEC_OFF_GATE      5'h08
`define AEC_OFF_COUNT     5'h0C
`define AEC_OFF_PWM_CMP   5'h10
`define AEC_OFF_PWM_DATA  5'h14
`define AEC_OFF_IRQ       5'h18

// ----------------------------------------------------------------------------
// Control/status register fields
// ----------------------------------------------------------------------------
`define AEC_CTRL_OVH      7
`define AEC_CTRL_OVL      6
`define AEC_CTRL_SPLIT    4
`define AEC_CTRL_HIGH_COUNT_ENABLE     3
`define AEC_CTRL_LOW_COUNT_ENABLE     2
`define AEC_CTRL_CRCH     1
`define AEC_CTRL_CRCL     0

// ----------------------------------------------------------------------------
// Clock select register fields (high select, high edge, low select, low edge)
// ----------------------------------------------------------------------------
`define AEC_CS_HSEL       7:6
`define AEC_CS_HEDGE      5:4
`define AEC_CS_LSEL       3:2
`define AEC_CS_LEDGE      1:0

// ----------------------------------------------------------------------------
// Gate register fields
// ----------------------------------------------------------------------------
`define AEC_GT_PWME       0
`define AEC_GT_EDGE       2:1
`define AEC_GT_PWMSEL     5:4

// ----------------------------------------------------------------------------
// Interrupt register fields
// ----------------------------------------------------------------------------
`define AEC_IRQ_CNT_REQ   0
`define AEC_IRQ_GATE_REQ  1
`define AEC_IRQ_CNT_EN    8
`define AEC_IRQ_GATE_EN   9

// ----------------------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------------------
`define AEC_RST_BYTE      8'h00
`define AEC_RST_WORD      16'h0000
`define AEC_CNT8_MAX      8'hFF
`define AEC_CNT8_ONE      8'h01
`define AEC_CNT16_ONE     16'h0001

`endif

/* src/aec_pkg.sv */
package aec_pkg;

  // Counter clock source; the reset value selects the event pin.
  typedef enum logic [1:0] {
    AEC_SRC_PIN  = 2'b00,
    AEC_SRC_DIV2 = 2'b01,
    AEC_SRC_DIV4 = 2'b10,
    AEC_SRC_DIV8 = 2'b11
  } aec_src_e;

  // Edge sensing; the reset value senses falling edges.
  typedef enum logic [1:0] {
    AEC_EDGE_FALL = 2'b00,
    AEC_EDGE_RISE = 2'b01,
    AEC_EDGE_BOTH = 2'b10,
    AEC_EDGE_ALL  = 2'b11
  } aec_edge_e;

endpackage

/* src/aec_sync.sv */
`timescale 1ns/1ns
module aec_sync (
  input  wire logic i_clk,
  input  wire logic i_rstn,
  input  wire logic i_ce,
  input  wire logic i_pin,
  output logic      o_level,
  output logic      o_rise,
  output logic      o_fall
);

  logic       s1_ff, s2_ff, s3_ff, lvl_ff, rise_ff, fall_ff;
  logic [1:0] warm_ff;
  wire        armed = (warm_ff == 2'b11);
  wire        agree = (s2_ff == s3_ff);
  wire        chg   = armed && agree && (s2_ff != lvl_ff);

  // Three stages; a change is taken only once stages two and three agree.
  // The stages reset to 0 whatever the pin shows, so the level is loaded
  // silently until real samples fill stages two and three; otherwise a pin
  // that idles high would report a false rising edge after every reset.
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      {s1_ff, s2_ff, s3_ff, lvl_ff, rise_ff, fall_ff} <= 6'h00;
      warm_ff <= 2'b00;
    end else if (i_ce) begin
      s1_ff   <= i_pin;
      s2_ff   <= s1_ff;
      s3_ff   <= s2_ff;
      warm_ff <= armed ? warm_ff : warm_ff + 2'b01;
      lvl_ff  <= (agree || !armed) ? s2_ff : lvl_ff;
      rise_ff <= chg && s2_ff;
      fall_ff <= chg && !s2_ff;
    end
  end

  assign o_level = lvl_ff;
  assign o_rise  = rise_ff;
  assign o_fall  = fall_ff;

endmodule

/* src/aec_pwm.sv */
`timescale 1ns/1ns
`include "aec_defs.svh"
module aec_pwm (
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_ce,
  input  wire logic        i_en,
  input  wire logic        i_tick,
  input  wire logic [15:0] i_cmp,
  input  wire logic [15:0] i_data,
  output logic             o_out
);

  logic [15:0] cnt_ff;
  logic        out_ff;
  wire  [15:0] nxt_cnt = (cnt_ff == i_cmp) ? `AEC_RST_WORD : cnt_ff + `AEC_CNT16_ONE;

  // Low for data+1 periods, high for the rest of a cmp+1 period frame.
  always_ff @(posedge i_clk) begin
    if (!i_rstn || (i_ce && !i_en)) begin
      cnt_ff <= `AEC_RST_WORD;
      out_ff <= 1'b0;
    end else if (i_ce && i_tick) begin
      cnt_ff <= nxt_cnt;
      out_ff <= (nxt_cnt > i_data);
    end
  end

  assign o_out = out_ff;

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  property p_pwm_rise;
    @(posedge i_clk) disable iff (!i_rstn)
      (i_ce && i_en && i_tick && !out_ff && nxt_cnt > i_data) |=> out_ff;
  endproperty
  a_pwm_rise: assert property (p_pwm_rise) else $error("pwm output did not rise");

endmodule

/* src/aec_top.sv */
// Operation
// - Split bit 0 chains high and low counters into one 16-bit counter.
// - In 16-bit mode low counter overflow increments the high counter.
// - 16-bit mode low clock: clk/2, clk/4, clk/8 or low pin, by low select.
// - Reset gives split 0 and low select 00: 16-bit, low pin falling edges.
// - Low edge select picks which low pin edges count.
// - 16-bit count FFFF wraps to 0000, sets high overflow, keeps counting.
// - Any overflow sets counter request; forwarded when its enable is 1.
// - Split bit 1 runs two independent 8-bit counters.
// - 8-bit mode high clock: clk/2, clk/4, clk/8 or high pin, by high select.
// - High edge select picks which high pin edges count.
// - 8-bit high counter at FF wraps to 00 and sets high overflow.
// - 8-bit low counter at FF wraps to 00 and sets low overflow.
// - A counter counts only while its count enable is 1, else holds.
// - PWM gating off: counters count only while gate pin is high.
// - Gating acts on both counters together, never separately.
// - Gate pin edges are also an interrupt source.
// - Gate interrupt sets gate request; forwarded when gate enable is 1.
// - Gate edge select picks rising, falling or both gate pin edges.
// - PWM gating on: counters count only while PWM output is high.
// - PWM output edges set the same gate request flag.
// - Same gate edge select applies to PWM output edges.
// - Gating cuts counting abruptly; one count error is acceptable.
`timescale 1ns/1ns
`include "aec_defs.svh"
module aec_top
  import aec_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_ce,
  input  wire logic        i_low_event_pin,
  input  wire logic        i_high_event_pin,
  input  wire logic        i_gate_pin,
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic [31:0]      o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  output logic             o_counter_irq,
  output logic             o_gate_irq,
  output logic             o_pwm_gate_output
);

  // ----------------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------------

  // Prescaler strobe for a divided source; the pin source yields none.
  function automatic logic div_tick(input logic [1:0] sel, input logic [3:0] p);
    case (sel)
      AEC_SRC_DIV2: div_tick = p[0];
      AEC_SRC_DIV4: div_tick = &p[1:0];
      AEC_SRC_DIV8: div_tick = &p[2:0];
      default:      div_tick = 1'b0;
    endcase
  endfunction

  // Edge selection shared by the event pins, the gate pin and the PWM output.
  function automatic logic edge_hit(input logic [1:0] sel, input logic r, input logic f);
    case (sel)
      AEC_EDGE_FALL: edge_hit = f;
      AEC_EDGE_RISE: edge_hit = r;
      default:       edge_hit = r | f;
    endcase
  endfunction

  // ----------------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------------
  logic [7:0]  ctrl_ff;
  logic [7:0]  clksel_ff;
  logic [7:0]  gate_ff;
  logic [15:0] pwm_cmp_ff;
  logic [15:0] pwm_data_ff;
  logic        cnt_req_ff, gate_req_ff, cnt_en_ff, gate_en_ff;
  logic [7:0]  low_ff, high_ff;
  logic [3:0]  presc_ff;
  logic        wr_pend_ff, rd_pend_ff;
  logic [2:0]  idx_ff;
  logic [31:0] hrdata_ff;
  logic        hreadyout_ff, counter_irq_ff, gate_irq_ff;

  // ----------------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------------
  logic low_lvl, low_rise, low_fall;
  logic high_lvl, high_rise, high_fall;
  logic gate_lvl, gate_rise, gate_fall;
  logic pwm_out;
  logic pwm_d_ff;

  aec_sync u_sync_low (
    .i_clk   (i_clk),
    .i_rstn  (i_rstn),
    .i_ce    (i_ce),
    .i_pin   (i_low_event_pin),
    .o_level (low_lvl),
    .o_rise  (low_rise),
    .o_fall  (low_fall)
  );

  aec_sync u_sync_high (
    .i_clk   (i_clk),
    .i_rstn  (i_rstn),
    .i_ce    (i_ce),
    .i_pin   (i_high_event_pin),
    .o_level (high_lvl),
    .o_rise  (high_rise),
    .o_fall  (high_fall)
  );

  aec_sync u_sync_gate (
    .i_clk   (i_clk),
    .i_rstn  (i_rstn),
    .i_ce    (i_ce),
    .i_pin   (i_gate_pin),
    .o_level (gate_lvl),
    .o_rise  (gate_rise),
    .o_fall  (gate_fall)
  );

  // ----------------------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------------------
  wire       split   = ctrl_ff[`AEC_CTRL_SPLIT];
  wire       high_count_enable    = ctrl_ff[`AEC_CTRL_HIGH_COUNT_ENABLE];
  wire       low_count_enable    = ctrl_ff[`AEC_CTRL_LOW_COUNT_ENABLE];
  wire       crch    = ctrl_ff[`AEC_CTRL_CRCH];
  wire       crcl    = ctrl_ff[`AEC_CTRL_CRCL];
  wire [1:0] lsel    = clksel_ff[`AEC_CS_LSEL];
  wire [1:0] hsel    = clksel_ff[`AEC_CS_HSEL];
  wire       pwm_en  = gate_ff[`AEC_GT_PWME];
  wire [1:0] gedge   = gate_ff[`AEC_GT_EDGE];
  wire [1:0] pwm_sel = gate_ff[`AEC_GT_PWMSEL];

  // PWM source period is clk/2, /4, /8 or /16.
  wire pwm_tick = (pwm_sel == 2'b11) ? &presc_ff : div_tick(2'(pwm_sel + 2'b01), presc_ff);

  aec_pwm u_pwm (
    .i_clk  (i_clk),
    .i_rstn (i_rstn),
    .i_ce   (i_ce),
    .i_en   (pwm_en),
    .i_tick (pwm_tick),
    .i_cmp  (pwm_cmp_ff),
    .i_data (pwm_data_ff),
    .o_out  (pwm_out)
  );

  // One gate level serves both counters, so they cannot be gated apart.
  wire gate_open = pwm_en ? pwm_out : gate_lvl;

  // Edges of whichever signal gates the counters raise the gate request.
  wire pwm_rise = pwm_out && !pwm_d_ff;
  wire pwm_fall = !pwm_out && pwm_d_ff;
  wire gate_hit = pwm_en ? edge_hit(gedge, pwm_rise, pwm_fall)
                         : edge_hit(gedge, gate_rise, gate_fall);

  // ----------------------------------------------------------------------------
  // Counter clocks
  // ----------------------------------------------------------------------------
  // Gating is applied to the tick itself, so a gate change mid-period simply
  // drops or keeps that tick; this is the tolerated one-count error.
  wire low_src  = (lsel == AEC_SRC_PIN) ? edge_hit(clksel_ff[`AEC_CS_LEDGE],
                  low_rise, low_fall) : div_tick(lsel, presc_ff);
  wire high_src = (hsel == AEC_SRC_PIN) ? edge_hit(clksel_ff[`AEC_CS_HEDGE],
                  high_rise, high_fall) : div_tick(hsel, presc_ff);
  wire tick_l   = low_count_enable && gate_open && low_src;
  wire tick_h   = high_count_enable && gate_open && high_src;
  wire low_top  = (low_ff == `AEC_CNT8_MAX);
  wire high_top = (high_ff == `AEC_CNT8_MAX);

  // In 16-bit mode the high counter is clocked by the low counter's carry.
  wire inc_l    = crcl && tick_l;
  wire inc_h    = crch && (split ? tick_h : (inc_l && low_top && high_count_enable));
  wire set_ovl  = split && inc_l && low_top;
  wire set_ovh  = inc_h && high_top;
  wire set_creq = set_ovl || set_ovh;

  // ----------------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------------
  wire       accept = i_hsel && i_htrans[1] && i_hready;
  wire       wr_now = wr_pend_ff;
  wire [4:0] woff   = {idx_ff, 2'b00};
  wire       wr_ctl = wr_now && (woff == `AEC_OFF_CTRL);
  wire       wr_cs  = wr_now && (woff == `AEC_OFF_CLKSEL);
  wire       wr_gt  = wr_now && (woff == `AEC_OFF_GATE);
  wire       wr_cmp = wr_now && (woff == `AEC_OFF_PWM_CMP);
  wire       wr_dat = wr_now && (woff == `AEC_OFF_PWM_DATA);
  wire       wr_irq = wr_now && (woff == `AEC_OFF_IRQ);

  // Overflow and request flags clear on a written 0; a set in the same cycle wins.
  wire clr_ovh  = wr_ctl && !i_hwdata[`AEC_CTRL_OVH];
  wire clr_ovl  = wr_ctl && !i_hwdata[`AEC_CTRL_OVL];
  wire clr_creq = wr_irq && !i_hwdata[`AEC_IRQ_CNT_REQ];
  wire clr_greq = wr_irq && !i_hwdata[`AEC_IRQ_GATE_REQ];
  wire nxt_ovh  = set_ovh || (ctrl_ff[`AEC_CTRL_OVH] && !clr_ovh);
  wire nxt_ovl  = set_ovl || (ctrl_ff[`AEC_CTRL_OVL] && !clr_ovl);
  wire nxt_creq = set_creq || (cnt_req_ff && !clr_creq);
  wire nxt_greq = gate_hit || (gate_req_ff && !clr_greq);
  wire [7:0] nxt_ctrl = {nxt_ovh, nxt_ovl,
                         wr_ctl ? i_hwdata[5:0] : ctrl_ff[5:0]};

  // Read mux for the data phase of a read.
  wire [4:0]  roff = {idx_ff, 2'b00};
  wire [31:0] nxt_hrdata =
    (roff == `AEC_OFF_CTRL)     ? {24'h000000, ctrl_ff}     :
    (roff == `AEC_OFF_CLKSEL)   ? {24'h000000, clksel_ff}   :
    (roff == `AEC_OFF_GATE)     ? {24'h000000, gate_ff}     :
    (roff == `AEC_OFF_COUNT)    ? {16'h0000, high_ff, low_ff} :
    (roff == `AEC_OFF_PWM_CMP)  ? {16'h0000, pwm_cmp_ff}    :
    (roff == `AEC_OFF_PWM_DATA) ? {16'h0000, pwm_data_ff}   :
    (roff == `AEC_OFF_IRQ)      ? {22'h0, gate_en_ff, cnt_en_ff,
                                   6'h00, gate_req_ff, cnt_req_ff} :
    32'h00000000;

  // ----------------------------------------------------------------------------
  // Bus slave: writes take no wait, reads one wait state
  // ----------------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      wr_pend_ff   <= 1'b0;
      rd_pend_ff   <= 1'b0;
      idx_ff       <= 3'h0;
      hrdata_ff    <= 32'h00000000;
      hreadyout_ff <= 1'b1;
    end else if (i_ce) begin
      wr_pend_ff   <= accept && i_hwrite;
      rd_pend_ff   <= accept && !i_hwrite;
      idx_ff       <= accept ? i_haddr[4:2] : idx_ff;
      hrdata_ff    <= rd_pend_ff ? nxt_hrdata : hrdata_ff;
      hreadyout_ff <= !(accept && !i_hwrite);
    end
  end

  // ----------------------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------------------
  // Reset clears split and both selects: 16-bit, low pin, falling edges.
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      ctrl_ff     <= `AEC_RST_BYTE;
      clksel_ff   <= `AEC_RST_BYTE;
      gate_ff     <= `AEC_RST_BYTE;
      pwm_cmp_ff  <= `AEC_RST_WORD;
      pwm_data_ff <= `AEC_RST_WORD;
    end else if (i_ce) begin
      ctrl_ff     <= nxt_ctrl;
      clksel_ff   <= wr_cs ? i_hwdata[7:0] : clksel_ff;
      gate_ff     <= wr_gt ? i_hwdata[7:0] : gate_ff;
      pwm_cmp_ff  <= wr_cmp ? i_hwdata[15:0] : pwm_cmp_ff;
      pwm_data_ff <= wr_dat ? i_hwdata[15:0] : pwm_data_ff;
    end
  end

  // Interrupt requests, enables and their registered outputs.
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      {cnt_req_ff, gate_req_ff, cnt_en_ff, gate_en_ff} <= 4'h0;
      {counter_irq_ff, gate_irq_ff} <= 2'b00;
    end else if (i_ce) begin
      cnt_req_ff     <= nxt_creq;
      gate_req_ff    <= nxt_greq;
      cnt_en_ff      <= wr_irq ? i_hwdata[`AEC_IRQ_CNT_EN] : cnt_en_ff;
      gate_en_ff     <= wr_irq ? i_hwdata[`AEC_IRQ_GATE_EN] : gate_en_ff;
      counter_irq_ff <= cnt_req_ff && cnt_en_ff;
      gate_irq_ff    <= gate_req_ff && gate_en_ff;
    end
  end

  // ----------------------------------------------------------------------------
  // Counters and prescaler
  // ----------------------------------------------------------------------------
  // A cleared reset-control bit holds its counter at zero.
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      low_ff   <= `AEC_RST_BYTE;
      high_ff  <= `AEC_RST_BYTE;
      presc_ff <= 4'h0;
      pwm_d_ff <= 1'b0;
    end else if (i_ce) begin
      low_ff   <= !crcl ? `AEC_RST_BYTE : low_ff + (inc_l ? `AEC_CNT8_ONE : `AEC_RST_BYTE);
      high_ff  <= !crch ? `AEC_RST_BYTE : high_ff + (inc_h ? `AEC_CNT8_ONE : `AEC_RST_BYTE);
      presc_ff <= presc_ff + 4'h1;
      pwm_d_ff <= pwm_out;
    end
  end

  // Software is trusted to keep PWM data below compare when enabling gating;
  // otherwise the output never rises and counting stalls.

  assign o_hrdata          = hrdata_ff;
  assign o_hreadyout       = hreadyout_ff;
  assign o_hresp           = 1'b0;
  assign o_counter_irq     = counter_irq_ff;
  assign o_gate_irq        = gate_irq_ff;
  assign o_pwm_gate_output = pwm_out;

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  property p_low_hold;
    (i_ce && !low_count_enable && crcl) |=> (low_ff == $past(low_ff));
  endproperty
  a_low_hold: assert property (p_low_hold) else $error("low counter moved while disabled");

  property p_gate_stop;
    (i_ce && !pwm_en && !gate_lvl && crcl && crch) |=>
      (low_ff == $past(low_ff)) && (high_ff == $past(high_ff));
  endproperty
  a_gate_stop: assert property (p_gate_stop) else $error("count while gate pin low");

  property p_pwm_stop;
    (i_ce && pwm_en && !pwm_out && crcl) |=> (low_ff == $past(low_ff));
  endproperty
  a_pwm_stop: assert property (p_pwm_stop) else $error("count while pwm output low");

  property p_wrap16;
    (i_ce && !split && inc_l && high_count_enable && crch && low_top && high_top) |=>
      ({high_ff, low_ff} == 16'h0000) && ctrl_ff[`AEC_CTRL_OVH];
  endproperty
  a_wrap16: assert property (p_wrap16) else $error("16-bit wrap wrong");

  property p_carry;
    (i_ce && !split && inc_l && high_count_enable && crch && low_top && !high_top) |=>
      (high_ff == $past(high_ff) + 8'h01);
  endproperty
  a_carry: assert property (p_carry) else $error("carry into high counter lost");

  property p_low8;
    (i_ce && split && inc_l && low_top) |=> (low_ff == 8'h00) && ctrl_ff[`AEC_CTRL_OVL];
  endproperty
  a_low8: assert property (p_low8) else $error("low 8-bit wrap wrong");

  property p_high8;
    (i_ce && split && crch && tick_h && high_top) |=>
      (high_ff == 8'h00) && ctrl_ff[`AEC_CTRL_OVH];
  endproperty
  a_high8: assert property (p_high8) else $error("high 8-bit wrap wrong");

  property p_cnt_irq;
    (i_ce && set_creq) ##1 (i_ce && cnt_en_ff) |=> o_counter_irq;
  endproperty
  a_cnt_irq: assert property (p_cnt_irq) else $error("counter interrupt missing");

  property p_gate_irq;
    (i_ce && gate_hit) |=> gate_req_ff;
  endproperty
  a_gate_irq: assert property (p_gate_irq) else $error("gate request not set");

endmodule

/* sim/aec_ext_pins.sv */
`timescale 1ns/1ns
module aec_ext_pins (
  input  wire logic i_clk,
  output logic      o_low,
  output logic      o_high,
  output logic      o_gate
);
  // Pins idle high, so a pulse starts with a falling edge.
  initial begin
    o_low  = 1'b1;
    o_high = 1'b1;
    o_gate = 1'b1;
  end
  // Each level stands four clocks; two is the least the syncs accept.
  task automatic toggle(input int sel, input int t);
    for (int i = 0; i < t; i++) begin
      @(posedge i_clk);
      if (sel == 0) o_low <= ~o_low;
      else if (sel == 1) o_high <= ~o_high;
      else o_gate <= ~o_gate;
      repeat (3) @(posedge i_clk);
    end
  endtask
endmodule

/* sim/test_aec_top.sv */
`timescale 1ns/1ns
module test_aec_top;
  logic        clk, rstn, hsel, hwrite, cirq, girq, pwm, low, high, gate, hready, hresp, ce;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  int          n_mismatch, n_checks, nh, nl;

  aec_ext_pins aec_ext_pins_inst (.i_clk(clk), .o_low(low), .o_high(high), .o_gate(gate));
  aec_top aec_top_inst (.i_clk(clk), .i_rstn(rstn), .i_ce(ce), .i_low_event_pin(low),
    .i_high_event_pin(high), .i_gate_pin(gate), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
    .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
    .o_counter_irq(cirq), .o_gate_irq(girq), .o_pwm_gate_output(pwm));

  // --------------------
  // Clock and helpers
  // --------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Wait for hready with a bound; a hung slave ends the run.
  task automatic wait_rdy;
    int k;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (hready !== 1'b1 && k < 50);
    if (hready !== 1'b1) begin
      n_mismatch++;
      give_verdict();
    end
  endtask

  // One single word transfer; read data is taken at the closing edge.
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= wr;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    check(q, exp);
  endtask

  // Counts the cycles for which the PWM output stays at one level.
  task automatic run(input logic lvl, output int n);
    n = 0;
    while (pwm === lvl && n < 500) begin
      @(posedge clk);
      n++;
    end
    if (pwm === lvl) begin
      n_mismatch++;
      give_verdict();
    end
  endtask

  // --------------------
  // Scenarios
  // --------------------
  task automatic t_reset;
    for (int a = 0; a < 32; a += 4) rd_chk(32'(a), 32'h0000_0000);
    check({31'h0, hresp}, 32'h0000_0000);
  endtask

  // Low pin edges, edge modes, gating by the gate pin and its request.
  task automatic t_pin16;
    bus(1'b1, 32'h00, 32'h0000_000F);
    aec_ext_pins_inst.toggle(0, 6);
    repeat (8) @(posedge clk);
    rd_chk(32'h0C, 32'h0000_0003);
    bus(1'b1, 32'h04, 32'h0000_0002);
    aec_ext_pins_inst.toggle(0, 4);
    repeat (8) @(posedge clk);
    rd_chk(32'h0C, 32'h0000_0007);
    bus(1'b1, 32'h18, 32'h0000_0200);
    aec_ext_pins_inst.toggle(2, 1);
    aec_ext_pins_inst.toggle(0, 4);
    repeat (8) @(posedge clk);
    rd_chk(32'h0C, 32'h0000_0007);
    rd_chk(32'h18, 32'h0000_0202);
    check({31'h0, girq}, 32'h0000_0001);
    bus(1'b1, 32'h18, 32'h0000_0200);
    bus(1'b1, 32'h08, 32'h0000_0002);
    aec_ext_pins_inst.toggle(2, 1);
    repeat (8) @(posedge clk);
    rd_chk(32'h18, 32'h0000_0202);
  endtask

  // Split mode: the high pin counts rising edges and leaves the low counter alone.
  task automatic t_pin8;
    bus(1'b1, 32'h00, 32'h0000_0000);
    bus(1'b1, 32'h04, 32'h0000_0010);
    bus(1'b1, 32'h00, 32'h0000_001F);
    aec_ext_pins_inst.toggle(1, 6);
    repeat (8) @(posedge clk);
    rd_chk(32'h0C, 32'h0000_0300);
  endtask

  // Divided clocks, wraps, flags, the disabled counter and the carry.
  task automatic t_ovf;
    bus(1'b1, 32'h00, 32'h0000_0000);
    bus(1'b1, 32'h18, 32'h0000_0000);
    bus(1'b1, 32'h04, 32'h0000_0044);
    bus(1'b1, 32'h00, 32'h0000_001B);
    repeat (600) @(posedge clk);
    rd_chk(32'h00, 32'h0000_009B);
    bus(1'b0, 32'h0C, 32'h0000_0000);
    check({24'h0, q[7:0]}, 32'h0000_0000);
    rd_chk(32'h18, 32'h0000_0001);
    check({31'h0, cirq}, 32'h0000_0000);
    bus(1'b1, 32'h18, 32'h0000_0101);
    repeat (3) @(posedge clk);
    check({31'h0, cirq}, 32'h0000_0001);
    bus(1'b1, 32'h00, 32'h0000_0017);
    repeat (600) @(posedge clk);
    rd_chk(32'h00, 32'h0000_0057);
    bus(1'b1, 32'h00, 32'h0000_0000);
    bus(1'b1, 32'h00, 32'h0000_000F);
    repeat (600) @(posedge clk);
    bus(1'b0, 32'h0C, 32'h0000_0000);
    check({24'h0, q[15:8]}, 32'h0000_0001);
  endtask

  // PWM gate with T of two clocks: low 2*(3+1), high 2*(9-3).
  task automatic t_pwm;
    bus(1'b1, 32'h18, 32'h0000_0200);
    bus(1'b1, 32'h10, 32'h0000_0009);
    bus(1'b1, 32'h14, 32'h0000_0003);
    bus(1'b1, 32'h08, 32'h0000_0001);
    run(1'b1, nh);
    run(1'b0, nl);
    run(1'b1, nh);
    run(1'b0, nl);
    check(32'(nh), 32'd12);
    check(32'(nl), 32'd8);
    rd_chk(32'h18, 32'h0000_0202);
    // A low clock enable must hold the PWM output where it stands.
    ce <= 1'b0;
    @(posedge clk);
    q  = {31'h0, pwm};
    nh = 0;
    repeat (30) begin
      @(posedge clk);
      if ({31'h0, pwm} !== q) nh++;
    end
    ce <= 1'b1;
    check(32'(nh), 32'd0);
  endtask

  // --------------------
  // Main sequence
  // --------------------
  initial begin
    n_mismatch = 0;
    n_checks   = 0;
    rstn       = 1'b0;
    ce         = 1'b1;
    hsel       = 1'b0;
    haddr      = 32'h0000_0000;
    htrans     = 2'b00;
    hwrite     = 1'b0;
    hsize      = 3'b010;
    hwdata     = 32'h0000_0000;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_pin16();
    t_pin8();
    t_ovf();
    t_pwm();
    give_verdict();
  end
endmodule
